// File: testbench/test_xae_core.sv
`timescale 1ns/1ns
`default_nettype none
module test_xae_core;
  import xae_pkg::*;
  logic clk_sys_i = 1'b0;
  logic reset_n_i = 1'b0;
  xae_sfr_s sfr_i = '0;
  xae_cmd_s cmd_i = '0;
  logic [7:0] sfr_rdata_o, xbus_rdata_i, xdata_rdata_o;
  logic [15:0] code_addr_o, ptr_o;
  logic code_strobe_o, xdata_done_o;
  logic xmem_wide_i = 1'b0;
  xae_xbus_s xbus_o;
  logic [XAE_NPORT-1:0][7:0] pin_level_i = '0;
  logic [XAE_NPORT-1:0][7:0] hub_i = '0;
  logic [XAE_NPORT-1:0][7:0] pin_out_o;
  int num_errors = 0;
  int tests_run = 0;
  int seed = 42;
  logic [7:0] q_sfr[$];
  logic [7:0] q_rd[$];
  logic [39:0] q_bus[$];
  logic [15:0] q_code[$];
  logic sfr_rd_d = 1'b0;
  logic bus_rd_d = 1'b0;
  logic bus_any_d = 1'b0;

  always #2 clk_sys_i = ~clk_sys_i;

  xae_core u_dut (.clk_sys_i, .reset_n_i, .sfr_i, .sfr_rdata_o, .cmd_i,
    .code_addr_o, .code_strobe_o, .ptr_o, .xbus_o, .xbus_rdata_i,
    .xmem_wide_i, .xdata_rdata_o, .xdata_done_o, .pin_level_i,
    .hub_port_output_value_i(hub_i), .pin_out_o);

  xae_xbus_model u_mem (.clk_sys_i, .reset_n_i, .xbus_i(xbus_o),
    .rdata_o(xbus_rdata_i));

  task automatic end_of_test();
    $display("checks %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : end_of_test

  task automatic check(input logic [39:0] seen, input logic [39:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // results are matched against the oldest note of their kind
  always @(posedge clk_sys_i)
  begin
    sfr_rd_d <= sfr_i.rd;
    bus_rd_d <= xbus_o.rd;
    bus_any_d <= xbus_o.rd || xbus_o.wr;
    if (bus_any_d)
      check(xdata_done_o, 1'b1);
    if (sfr_rd_d)
      check(sfr_rdata_o, q_sfr.size() ? q_sfr.pop_front() : 'x);
    if (xbus_o.rd || xbus_o.wr)
      check({xbus_o.wr, xbus_o.wr ? xbus_o.wdata : 8'h00, xbus_o.addr,
        xbus_o.region, xbus_o.hi_lane},
        q_bus.size() ? q_bus.pop_front() : 'x);
    if (xdata_done_o && bus_rd_d)
      check(xdata_rdata_o, q_rd.size() ? q_rd.pop_front() : 'x);
    if (code_strobe_o)
      check(code_addr_o, q_code.size() ? q_code.pop_front() : 'x);
  end

  task automatic sfr(input logic wr, input logic [7:0] a,
                     input logic [7:0] d);
    @(posedge clk_sys_i);
    #1 sfr_i = '{rd: !wr, wr: wr, addr: a, wdata: d};
    @(posedge clk_sys_i);
    #1 sfr_i = '0;
  endtask : sfr

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    q_sfr.push_back(exp);
    sfr(1'b0, a, 8'h00);
  endtask : rd

  task automatic cmd(input xae_op_e op, input logic [15:0] imm);
    @(posedge clk_sys_i);
    #1 cmd_i = '{op: op, ri: imm[7:0], acc: imm[15:8], imm: imm,
      wdata: imm[7:0] ^ 8'h3c};
    @(posedge clk_sys_i);
    #1 cmd_i = '0;
  endtask : cmd

  task automatic xmove(input xae_op_e op, input logic [23:0] a,
                       input xae_region_e rg, input logic [15:0] imm);
    logic w;
    logic hi;
    w = (op == XAE_OP_XWR_DP) || (op == XAE_OP_XWR_RI);
    hi = xmem_wide_i & a[0];
    q_bus.push_back({w, w ? imm[7:0] ^ 8'h3c : 8'h00, a, rg, hi});
    if (!w)
      q_rd.push_back(rg == XAE_RG_NONE ? 8'h00 :
        a[7:0] ^ a[23:16] ^ {hi, 7'h00});
    cmd(op, imm);
  endtask : xmove

  initial
  begin
    repeat (20000) @(posedge clk_sys_i);
    num_errors++;
    $display("MISMATCH t=%0t run limit reached", $time);
    end_of_test();
  end

  initial
  begin
    logic [7:0] regs[5] = '{XAE_SFR_PTR_CHOICE, XAE_SFR_PTR0_UPPER,
      XAE_SFR_PTR1_UPPER, XAE_SFR_IDX_UPPER, XAE_SFR_IDX_MIDDLE};
    logic [27:0] tbl[21] = '{{24'h000000, XAE_RG_SRAM},
      {24'h001fff, XAE_RG_SRAM}, {24'h002000, XAE_RG_NONE},
      {24'h005000, XAE_RG_PORTS}, {24'h0051ff, XAE_RG_PORTS},
      {24'h005200, XAE_RG_NONE}, {24'h005400, XAE_RG_XMEM_CTL},
      {24'h0054ff, XAE_RG_XMEM_CTL}, {24'h007000, XAE_RG_HUB_CFG},
      {24'h008fff, XAE_RG_NVM}, {24'h010000, XAE_RG_DIC},
      {24'h01ffff, XAE_RG_DIC}, {24'h05021f, XAE_RG_NONE},
      {24'h050220, XAE_RG_DBG}, {24'h0502f0, XAE_RG_DBG},
      {24'h0502f1, XAE_RG_NONE}, {24'h080000, XAE_RG_ECC},
      {24'h081fff, XAE_RG_ECC}, {24'h7fffff, XAE_RG_NONE},
      {24'h800000, XAE_RG_EXTMEM}, {24'hffffff, XAE_RG_EXTMEM}};
    logic [7:0] f;
    logic [7:0] s;
    logic [7:0] h;
    repeat (2) @(posedge clk_sys_i);
    #1 reset_n_i = 1'b1;
    for (int i = 0; i < 5; i++)
      rd(regs[i], 8'h00);
    for (int i = 1; i < 5; i++)
      sfr(1'b1, regs[i], 8'(i * 8'h11));
    for (int i = 1; i < 5; i++)
      rd(regs[i], 8'(i * 8'h11));
    sfr(1'b1, XAE_SFR_PTR_CHOICE, 8'hff);
    rd(XAE_SFR_PTR_CHOICE, 8'h01);
    sfr(1'b1, 8'h87, 8'hff);
    rd(8'h87, 8'h00);
    // pointer 1 active now; load it, then fill pointer 0 by halves
    cmd(XAE_OP_LOAD, 16'hbeef);
    sfr(1'b1, XAE_SFR_PTR_CHOICE, 8'h00);
    sfr(1'b1, XAE_SFR_DPL0, 8'hcd);
    sfr(1'b1, XAE_SFR_DPH0, 8'hab);
    repeat (2) @(posedge clk_sys_i);
    check(ptr_o, 16'habcd);
    xmove(XAE_OP_XRD_DP, 24'h11abcd, XAE_RG_NONE, 16'h0000);
    sfr(1'b1, XAE_SFR_PTR_CHOICE, 8'h01);
    repeat (2) @(posedge clk_sys_i);
    check(ptr_o, 16'hbeef);
    xmove(XAE_OP_XWR_DP, 24'h22beef, XAE_RG_NONE, 16'h0077);
    // top byte from the indexed upper register (0x33), then middle (0x44)
    xmove(XAE_OP_XRD_RI, 24'h33445a, XAE_RG_NONE, 16'h005a);
    xmove(XAE_OP_XWR_RI, 24'h334401, XAE_RG_NONE, 16'h0001);
    q_code.push_back(16'hbef6);
    cmd(XAE_OP_CODE, 16'h0700);
    cmd(XAE_OP_INC, 16'h0000);
    repeat (2) @(posedge clk_sys_i);
    check(ptr_o, 16'hbef0);
    for (int i = 0; i < 21; i++)
    begin
      sfr(1'b1, XAE_SFR_PTR1_UPPER, tbl[i][27:20]);
      cmd(XAE_OP_LOAD, tbl[i][19:4]);
      xmem_wide_i = i[0];
      xmove(i[1] ? XAE_OP_XWR_DP : XAE_OP_XRD_DP, tbl[i][27:4],
        xae_region_e'(tbl[i][3:0]), 16'(i));
    end
    for (int p = 0; p < XAE_NPORT; p++)
    begin
      f = 8'($random(seed));
      s = 8'($random(seed));
      h = 8'($random(seed));
      hub_i[p] = h;
      sfr(1'b1, XAE_SFR_FPO[p], f);
      sfr(1'b1, XAE_SFR_FPS[p], s);
      repeat (2) @(posedge clk_sys_i);
      check(pin_out_o[p], (s & f) | (~s & h));
      #1 pin_level_i[p] = ~f;
      sfr(1'b1, XAE_SFR_FPL[p], f);
      repeat (3) @(posedge clk_sys_i);
      rd(XAE_SFR_FPL[p], ~f);
      rd(XAE_SFR_FPO[p], f);
    end
    for (int k = 0; k < 20 && (q_sfr.size() + q_rd.size() + q_bus.size()
         + q_code.size()) > 0; k++)
      @(posedge clk_sys_i);
    if ((q_sfr.size() + q_rd.size() + q_bus.size() + q_code.size()) > 0)
    begin
      num_errors++;
      $display("MISMATCH t=%0t expected results never appeared", $time);
    end
    end_of_test();
  end
endmodule : test_xae_core
`default_nettype wire

// File: testbench/xae_xbus_model.sv
`timescale 1ns/1ns
`default_nettype none
module xae_xbus_model
(
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  // external data bus from the block
  input wire xae_pkg::xae_xbus_s xbus_i,
  output logic [7:0] rdata_o
);
  import xae_pkg::*;
  logic [7:0] idle_reg;
  // released bus toggles so a stale byte can never pass as data
  always_ff @(posedge clk_sys_i)
  begin
    if (!reset_n_i)
      idle_reg <= 8'ha5;
    else
      idle_reg <= ~idle_reg;
  end
  // one memory width at a time; upper lane flips the top bit
  assign rdata_o = xbus_i.rd ? (xbus_i.addr[7:0] ^ xbus_i.addr[23:16] ^
    {xbus_i.hi_lane, 7'h00}) : idle_reg;
endmodule : xae_xbus_model
`default_nettype wire

// File: verilog/xae_core.sv
// Behaviour
// - pointer choice picks active data pointer
// - pointer moves take top byte from extension
// - indexed moves use top and middle bytes
// - extensions apply only to external moves
// - fast output register for nine ports
// - select one gives fast bit to pin
// - select zero gives hub bit to pin
// - pin level register read only
// - ports reachable via hub and special space
// - full address is twenty four bits
// - low region decodes to static RAM
// - top half goes to external memory
// - port control range decoded
// - memory interface control page decoded
// - nonvolatile data window decoded
// - interconnect configuration page decoded
// - error correction window decoded
// - hub configuration range decoded
// - debug window decoded only inside range
// - external memory eight or sixteen wide
`timescale 1ns/1ns
`default_nettype none
module xae_core
  import xae_pkg::*;
#(
  parameter int NPORT = XAE_NPORT
)
(
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  // special function register access from the core
  input wire xae_pkg::xae_sfr_s sfr_i,
  output var logic [7:0] sfr_rdata_o,
  // instruction commands from the core
  input wire xae_pkg::xae_cmd_s cmd_i,
  output var logic [15:0] code_addr_o,
  output var logic code_strobe_o,
  output var logic [15:0] ptr_o,
  // external data bus toward regions
  output var xae_pkg::xae_xbus_s xbus_o,
  input wire logic [7:0] xbus_rdata_i,
  input wire logic xmem_wide_i,
  output var logic [7:0] xdata_rdata_o,
  output var logic xdata_done_o,
  // port pins and hub-side output values
  input wire logic [NPORT-1:0][7:0] pin_level_i,
  input wire logic [NPORT-1:0][7:0] hub_port_output_value_i,
  output var logic [NPORT-1:0][7:0] pin_out_o
);
  import xae_pkg::*;

  logic data_pointer_select_reg;
  logic [1:0][15:0] data_pointer_reg;
  logic [1:0][7:0] pointer_upper_reg;
  logic [7:0] indexed_upper_reg;
  logic [7:0] indexed_middle_reg;
  logic [NPORT-1:0][7:0] fast_port_output_reg;
  logic [NPORT-1:0][7:0] fast_port_owner_reg;
  logic [NPORT-1:0][7:0] pin_meta_reg;
  logic [NPORT-1:0][7:0] pin_sync_reg;
  logic [7:0] sfr_rdata_next;
  logic [15:0] sel_ptr;
  logic [7:0] sel_upper;
  logic [23:0] xaddr_next;
  logic xrd_next;
  logic xwr_next;
  xae_region_e region;
  logic xbus_rd_reg, xbus_wr_reg, xbus_hi_reg;
  logic [23:0] xbus_addr_reg;
  logic [7:0] xbus_wdata_reg;

  assign sel_ptr = data_pointer_reg[data_pointer_select_reg];
  assign sel_upper = pointer_upper_reg[data_pointer_select_reg];

  // pins come from outside the clock domain
  always_ff @(posedge clk_sys_i)
  begin
    if (!reset_n_i)
    begin
      pin_meta_reg <= '0;
      pin_sync_reg <= '0;
    end
    else
    begin
      pin_meta_reg <= pin_level_i;
      pin_sync_reg <= pin_meta_reg;
    end
  end

  // pointer select and extension bytes
  always_ff @(posedge clk_sys_i)
  begin
    if (!reset_n_i)
    begin
      data_pointer_select_reg <= 1'b0;
      pointer_upper_reg <= {XAE_RST_BYTE, XAE_RST_BYTE};
      indexed_upper_reg <= XAE_RST_BYTE;
      indexed_middle_reg <= XAE_RST_BYTE;
    end
    else if (sfr_i.wr)
    begin
      unique case (sfr_i.addr)
        XAE_SFR_PTR_CHOICE:
          data_pointer_select_reg <= sfr_i.wdata[XAE_PTR_CHOICE_BIT];
        XAE_SFR_PTR0_UPPER: pointer_upper_reg[0] <= sfr_i.wdata;
        XAE_SFR_PTR1_UPPER: pointer_upper_reg[1] <= sfr_i.wdata;
        XAE_SFR_IDX_UPPER: indexed_upper_reg <= sfr_i.wdata;
        XAE_SFR_IDX_MIDDLE: indexed_middle_reg <= sfr_i.wdata;
        default: ;
      endcase
    end
  end

  // data pointers; an increment or load command wins over a same-cycle register write
  always_ff @(posedge clk_sys_i)
  begin
    if (!reset_n_i)
      data_pointer_reg <= '0;
    else if (cmd_i.op == XAE_OP_INC)
      data_pointer_reg[data_pointer_select_reg] <= sel_ptr + 16'h0001;
    else if (cmd_i.op == XAE_OP_LOAD)
      data_pointer_reg[data_pointer_select_reg] <= cmd_i.imm;
    else if (sfr_i.wr)
    begin
      unique case (sfr_i.addr)
        XAE_SFR_DPL0: data_pointer_reg[0][7:0] <= sfr_i.wdata;
        XAE_SFR_DPH0: data_pointer_reg[0][15:8] <= sfr_i.wdata;
        XAE_SFR_DPL1: data_pointer_reg[1][7:0] <= sfr_i.wdata;
        XAE_SFR_DPH1: data_pointer_reg[1][15:8] <= sfr_i.wdata;
        default: ;
      endcase
    end
  end

  // fast port registers; pin level addresses take no write
  always_ff @(posedge clk_sys_i)
  begin
    if (!reset_n_i)
    begin
      fast_port_output_reg <= '0;
      fast_port_owner_reg <= '0;
    end
    else if (sfr_i.wr)
    begin
      for (int p = 0; p < NPORT; p++)
      begin
        if (sfr_i.addr == XAE_SFR_FPO[p])
          fast_port_output_reg[p] <= sfr_i.wdata;
        if (sfr_i.addr == XAE_SFR_FPS[p])
          fast_port_owner_reg[p] <= sfr_i.wdata;
      end
    end
  end

  // register read mux, unmapped addresses read zero
  always_comb
  begin
    sfr_rdata_next = 8'h00;
    unique case (sfr_i.addr)
      XAE_SFR_DPL0: sfr_rdata_next = data_pointer_reg[0][7:0];
      XAE_SFR_DPH0: sfr_rdata_next = data_pointer_reg[0][15:8];
      XAE_SFR_DPL1: sfr_rdata_next = data_pointer_reg[1][7:0];
      XAE_SFR_DPH1: sfr_rdata_next = data_pointer_reg[1][15:8];
      XAE_SFR_PTR_CHOICE:
        sfr_rdata_next[XAE_PTR_CHOICE_BIT] = data_pointer_select_reg;
      XAE_SFR_PTR0_UPPER: sfr_rdata_next = pointer_upper_reg[0];
      XAE_SFR_PTR1_UPPER: sfr_rdata_next = pointer_upper_reg[1];
      XAE_SFR_IDX_UPPER: sfr_rdata_next = indexed_upper_reg;
      XAE_SFR_IDX_MIDDLE: sfr_rdata_next = indexed_middle_reg;
      default: ;
    endcase
    for (int p = 0; p < NPORT; p++)
    begin
      if (sfr_i.addr == XAE_SFR_FPO[p])
        sfr_rdata_next = fast_port_output_reg[p];
      if (sfr_i.addr == XAE_SFR_FPS[p])
        sfr_rdata_next = fast_port_owner_reg[p];
      if (sfr_i.addr == XAE_SFR_FPL[p])
        sfr_rdata_next = pin_sync_reg[p];
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!reset_n_i)
      sfr_rdata_o <= 8'h00;
    else if (sfr_i.rd)
      sfr_rdata_o <= sfr_rdata_next;
  end

  // pin ownership per bit
  always_ff @(posedge clk_sys_i)
  begin
    if (!reset_n_i)
      pin_out_o <= '0;
    else
      for (int p = 0; p < NPORT; p++)
        pin_out_o[p] <= (fast_port_owner_reg[p] & fast_port_output_reg[p])
          | (~fast_port_owner_reg[p] & hub_port_output_value_i[p]);
  end

  // external move address forming
  always_comb
  begin
    xaddr_next = 24'h000000;
    xrd_next = 1'b0;
    xwr_next = 1'b0;
    unique case (cmd_i.op)
      XAE_OP_XRD_DP, XAE_OP_XWR_DP:
      begin
        xaddr_next = {sel_upper, sel_ptr};
        xrd_next = (cmd_i.op == XAE_OP_XRD_DP);
        xwr_next = (cmd_i.op == XAE_OP_XWR_DP);
      end
      XAE_OP_XRD_RI, XAE_OP_XWR_RI:
      begin
        xaddr_next = {indexed_upper_reg, indexed_middle_reg, cmd_i.ri};
        xrd_next = (cmd_i.op == XAE_OP_XRD_RI);
        xwr_next = (cmd_i.op == XAE_OP_XWR_RI);
      end
      default: ;
    endcase
  end

  xae_xdata_decode u_decode (
    .clk_sys_i(clk_sys_i),
    .reset_n_i(reset_n_i),
    .addr_i(xaddr_next),
    .region_o(region)
  );

  always_ff @(posedge clk_sys_i)
  begin
    if (!reset_n_i)
    begin
      xbus_rd_reg <= 1'b0;
      xbus_wr_reg <= 1'b0;
      xbus_addr_reg <= 24'h000000;
      xbus_wdata_reg <= 8'h00;
      xbus_hi_reg <= 1'b0;
    end
    else
    begin
      xbus_rd_reg <= xrd_next;
      xbus_wr_reg <= xwr_next;
      xbus_addr_reg <= xaddr_next;
      xbus_wdata_reg <= cmd_i.wdata;
      // only one memory type at a time, width chosen by strap input
      xbus_hi_reg <= xmem_wide_i & xaddr_next[0];
    end
  end

  // one driver for the whole struct; region is already registered
  assign xbus_o = '{rd: xbus_rd_reg, wr: xbus_wr_reg, addr: xbus_addr_reg,
    region: region, wdata: xbus_wdata_reg, hi_lane: xbus_hi_reg};

  // answer one cycle after the strobe; no target can stall it
  always_ff @(posedge clk_sys_i)
  begin
    if (!reset_n_i)
    begin
      xdata_done_o <= 1'b0;
      xdata_rdata_o <= 8'h00;
    end
    else
    begin
      xdata_done_o <= xbus_o.rd | xbus_o.wr;
      if (xbus_o.rd)
        xdata_rdata_o <= (region == XAE_RG_NONE) ? 8'h00 : xbus_rdata_i;
    end
  end

  // code reads ignore every extension byte
  always_ff @(posedge clk_sys_i)
  begin
    if (!reset_n_i)
    begin
      code_addr_o <= 16'h0000;
      code_strobe_o <= 1'b0;
      ptr_o <= 16'h0000;
    end
    else
    begin
      code_strobe_o <= (cmd_i.op == XAE_OP_CODE);
      if (cmd_i.op == XAE_OP_CODE)
        code_addr_o <= sel_ptr + {8'h00, cmd_i.acc};
      ptr_o <= sel_ptr;
    end
  end

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);

  sequence s_dp_move;
    cmd_i.op == XAE_OP_XRD_DP || cmd_i.op == XAE_OP_XWR_DP;
  endsequence
  sequence s_ri_move;
    cmd_i.op == XAE_OP_XRD_RI || cmd_i.op == XAE_OP_XWR_RI;
  endsequence
  sequence s_read_strobe;
    xbus_o.rd ##1 xdata_done_o;
  endsequence

  property p_dp_addr;
    s_dp_move |=> xbus_o.addr == {$past(sel_upper), $past(sel_ptr)};
  endproperty
  a_dp_addr: assert property (p_dp_addr)
    else $error("pointer move address wrong");

  property p_ri_addr;
    s_ri_move |=> xbus_o.addr[23:8] ==
      {$past(indexed_upper_reg), $past(indexed_middle_reg)};
  endproperty
  a_ri_addr: assert property (p_ri_addr)
    else $error("indexed move address wrong");

  property p_code_plain;
    cmd_i.op == XAE_OP_CODE |=> code_strobe_o && !xbus_o.rd && !xbus_o.wr
      && code_addr_o == 16'($past(sel_ptr) + {8'h00, $past(cmd_i.acc)});
  endproperty
  a_code_plain: assert property (p_code_plain)
    else $error("code read touched external bus");

  property p_inc;
    cmd_i.op == XAE_OP_INC && !data_pointer_select_reg |=>
      data_pointer_reg[0] == 16'($past(data_pointer_reg[0]) + 16'h0001);
  endproperty
  a_inc: assert property (p_inc)
    else $error("selected pointer not incremented");

  property p_pin_fast;
    fast_port_owner_reg[0][0] |=> pin_out_o[0][0] ==
      $past(fast_port_output_reg[0][0]);
  endproperty
  a_pin_fast: assert property (p_pin_fast)
    else $error("fast bit does not drive pin");

  property p_pin_hub;
    !fast_port_owner_reg[1][3] |=> pin_out_o[1][3] ==
      $past(hub_port_output_value_i[1][3]);
  endproperty
  a_pin_hub: assert property (p_pin_hub)
    else $error("hub bit does not drive pin");

  property p_level_ro;
    sfr_i.wr && sfr_i.addr == XAE_SFR_FPL[2] |=>
      $stable(fast_port_output_reg) && $stable(fast_port_owner_reg);
  endproperty
  a_level_ro: assert property (p_level_ro)
    else $error("pin level write changed state");

  property p_sram;
    (xbus_o.rd || xbus_o.wr) && xbus_o.addr <= XAE_SRAM_HI |->
      region == XAE_RG_SRAM;
  endproperty
  a_sram: assert property (p_sram)
    else $error("low address not static RAM");

  property p_extmem;
    (xbus_o.rd || xbus_o.wr) && xbus_o.addr[23] |->
      region == XAE_RG_EXTMEM;
  endproperty
  a_extmem: assert property (p_extmem)
    else $error("top half not external memory");

  property p_unmapped;
    xbus_o.rd && region == XAE_RG_NONE |-> s_read_strobe
      ##0 xdata_rdata_o == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");

endmodule : xae_core
`default_nettype wire

// File: verilog/xae_pkg.sv
package xae_pkg;

  localparam int XAE_NPORT = 9;
  localparam logic [7:0] XAE_RST_BYTE = 8'h00;

  // pointer and extension registers in special function space
  localparam logic [7:0] XAE_SFR_DPL0 = 8'h82;
  localparam logic [7:0] XAE_SFR_DPH0 = 8'h83;
  localparam logic [7:0] XAE_SFR_DPL1 = 8'h84;
  localparam logic [7:0] XAE_SFR_DPH1 = 8'h85;
  localparam logic [7:0] XAE_SFR_PTR_CHOICE = 8'h86;
  localparam logic [7:0] XAE_SFR_PTR0_UPPER = 8'h93;
  localparam logic [7:0] XAE_SFR_PTR1_UPPER = 8'h95;
  localparam logic [7:0] XAE_SFR_IDX_UPPER = 8'hea;
  localparam logic [7:0] XAE_SFR_IDX_MIDDLE = 8'ha0;
  localparam int XAE_PTR_CHOICE_BIT = 0;

  // fast port registers, index 0..8 = ports 0..6, 12, 15
  localparam logic [XAE_NPORT-1:0][7:0] XAE_SFR_FPO = {8'hf8, 8'he8,
    8'hd8, 8'hc8, 8'hc0, 8'hb0, 8'h98, 8'h90, 8'h80};
  localparam logic [XAE_NPORT-1:0][7:0] XAE_SFR_FPL = {8'hf9, 8'he9,
    8'hd9, 8'hc9, 8'hc1, 8'hb1, 8'h99, 8'h91, 8'h89};
  localparam logic [XAE_NPORT-1:0][7:0] XAE_SFR_FPS = {8'hfa, 8'hf2,
    8'hda, 8'hca, 8'hc2, 8'hb2, 8'h9a, 8'ha2, 8'h8a};

  // external data regions, inclusive bounds
  localparam logic [23:0] XAE_SRAM_LO = 24'h000000;
  localparam logic [23:0] XAE_SRAM_HI = 24'h001fff;
  localparam logic [23:0] XAE_PORTS_LO = 24'h005000;
  localparam logic [23:0] XAE_PORTS_HI = 24'h0051ff;
  localparam logic [23:0] XAE_XMEMC_LO = 24'h005400;
  localparam logic [23:0] XAE_XMEMC_HI = 24'h0054ff;
  localparam logic [23:0] XAE_HUB_LO = 24'h007000;
  localparam logic [23:0] XAE_HUB_HI = 24'h007fff;
  localparam logic [23:0] XAE_NVM_LO = 24'h008000;
  localparam logic [23:0] XAE_NVM_HI = 24'h008fff;
  localparam logic [23:0] XAE_DIC_LO = 24'h010000;
  localparam logic [23:0] XAE_DIC_HI = 24'h01ffff;
  localparam logic [23:0] XAE_DBG_LO = 24'h050220;
  localparam logic [23:0] XAE_DBG_HI = 24'h0502f0;
  localparam logic [23:0] XAE_ECC_LO = 24'h080000;
  localparam logic [23:0] XAE_ECC_HI = 24'h081fff;
  localparam logic [23:0] XAE_EXT_LO = 24'h800000;
  localparam logic [23:0] XAE_EXT_HI = 24'hffffff;

  typedef enum logic [3:0] {
    XAE_RG_NONE, XAE_RG_SRAM, XAE_RG_PORTS, XAE_RG_XMEM_CTL,
    XAE_RG_HUB_CFG, XAE_RG_NVM, XAE_RG_DIC, XAE_RG_DBG, XAE_RG_ECC,
    XAE_RG_EXTMEM
  } xae_region_e;

  typedef enum logic [2:0] {
    XAE_OP_NONE, XAE_OP_XRD_DP, XAE_OP_XWR_DP, XAE_OP_XRD_RI,
    XAE_OP_XWR_RI, XAE_OP_CODE, XAE_OP_INC, XAE_OP_LOAD
  } xae_op_e;

  typedef struct packed {
    xae_op_e op;
    logic [7:0] ri;
    logic [7:0] acc;
    logic [15:0] imm;
    logic [7:0] wdata;
  } xae_cmd_s;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } xae_sfr_s;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [23:0] addr;
    xae_region_e region;
    logic [7:0] wdata;
    logic hi_lane;
  } xae_xbus_s;

  function automatic logic xae_in(input logic [23:0] a,
                                  input logic [23:0] lo,
                                  input logic [23:0] hi);
    return (a >= lo) && (a <= hi);
  endfunction : xae_in

endpackage : xae_pkg

// File: verilog/xae_xdata_decode.sv
`timescale 1ns/1ns
`default_nettype none
module xae_xdata_decode
  import xae_pkg::*;
(
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  // address under decode
  input wire logic [23:0] addr_i,
  // registered region, aligned with the address register outside
  output var xae_pkg::xae_region_e region_o
);
  import xae_pkg::*;

  xae_region_e region_next;

  always_comb
  begin
    region_next = XAE_RG_NONE;
    if (xae_in(addr_i, XAE_SRAM_LO, XAE_SRAM_HI))
      region_next = XAE_RG_SRAM;
    else if (xae_in(addr_i, XAE_PORTS_LO, XAE_PORTS_HI))
      region_next = XAE_RG_PORTS;
    else if (xae_in(addr_i, XAE_XMEMC_LO, XAE_XMEMC_HI))
      region_next = XAE_RG_XMEM_CTL;
    else if (xae_in(addr_i, XAE_HUB_LO, XAE_HUB_HI))
      region_next = XAE_RG_HUB_CFG;
    else if (xae_in(addr_i, XAE_NVM_LO, XAE_NVM_HI))
      region_next = XAE_RG_NVM;
    else if (xae_in(addr_i, XAE_DIC_LO, XAE_DIC_HI))
      region_next = XAE_RG_DIC;
    else if (xae_in(addr_i, XAE_DBG_LO, XAE_DBG_HI))
      region_next = XAE_RG_DBG;
    else if (xae_in(addr_i, XAE_ECC_LO, XAE_ECC_HI))
      region_next = XAE_RG_ECC;
    else if (xae_in(addr_i, XAE_EXT_LO, XAE_EXT_HI))
      region_next = XAE_RG_EXTMEM;
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!reset_n_i)
      region_o <= XAE_RG_NONE;
    else
      region_o <= region_next;
  end

endmodule : xae_xdata_decode
`default_nettype wire
